// *** dv/mfr_core_model.sv ***
// Behavioural processor core raising one-cycle event pulses
`timescale 1ns/10ps
module mfr_core_model
  import mfr_pkg::*;
(
  input  wire logic   clk_i,
  output mfr_core_ev_s ev_o
);
  // ==========================================================
  // Event launch
  initial begin
    ev_o = '0;
  end

  // Each event stands one cycle, then the bus goes quiet for a cycle
  task automatic send(input mfr_core_ev_s e);
    @(posedge clk_i);
    ev_o <= e;
    @(posedge clk_i);
    ev_o <= '0;
  endtask

  task automatic fetch(input logic [15:0] va);
    mfr_core_ev_s e;
    e = '0;
    e.fetch = 1'b1;
    e.fetch_va = va;
    send(e);
  endtask

  // Vector pulse comes only from hardware traps, never software traps
  task automatic hw_trap(input logic [15:0] vec);
    mfr_core_ev_s e;
    e = '0;
    e.hw_trap = 1'b1;
    e.vector = vec;
    send(e);
  endtask

  task automatic instr_end(input logic sw);
    mfr_core_ev_s e;
    e = '0;
    e.instr_end = 1'b1;
    e.sw_trap = sw;
    send(e);
  endtask

  task automatic autoinc(input logic [2:0] r, input logic [4:0] a);
    mfr_core_ev_s e;
    e = '0;
    e.autoinc = 1'b1;
    e.ai_reg = r;
    e.ai_amt = a;
    send(e);
  endtask

  // Flags are {nonresident, length, trap condition}
  task automatic mem_ref(input logic [1:0] m, input logic d, input logic [2:0] p,
                         input logic dst, input logic [2:0] f);
    mfr_core_ev_s e;
    e = '0;
    e.ref_valid = 1'b1;
    e.ref_mode = m;
    e.ref_dspace = d;
    e.ref_page = p;
    e.ref_dest = dst;
    {e.ab_nonres, e.ab_length, e.trap_cond} = f;
    send(e);
  endtask

  // Write attempt to a read-only page
  task automatic ro_ref(input logic [1:0] m, input logic d, input logic [2:0] p);
    mfr_core_ev_s e;
    e = '0;
    e.ref_valid = 1'b1;
    e.ref_mode = m;
    e.ref_dspace = d;
    e.ref_page = p;
    e.ab_rdonly = 1'b1;
    send(e);
  endtask
endmodule // mfr_core_model

// *** dv/mfr_regs_tb.sv ***
// Self-checking bench for the fault-recovery register block
`timescale 1ns/10ps
module mfr_regs_tb
  import mfr_pkg::*;
;
  logic         clk_i;
  logic         rst_i;
  logic         wb_cyc_i;
  logic         wb_stb_i;
  logic         wb_we_i;
  logic [4:0]   wb_adr_i;
  logic [3:0]   wb_sel_i;
  logic [31:0]  wb_dat_i;
  logic [31:0]  wb_dat_o;
  logic         wb_ack_o;
  mfr_core_ev_s ev_i;
  mfr_map_ctl_s map_ctl_o;
  logic         trap_req_o;
  logic         abort_req_o;
  logic [15:0]  rd;
  int           n_errors = 0;
  int           n_tests = 0;

  mfr_regs mfr_regs_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .ev_i(ev_i), .map_ctl_o(map_ctl_o), .trap_req_o(trap_req_o),
    .abort_req_o(abort_req_o)
  );

  mfr_core_model mfr_core_model_i (.clk_i(clk_i), .ev_o(ev_i));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // ==========================================================
  // Shared tasks
  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Classic single cycle, held until ack is sampled high
  task automatic wbs(input logic we, input logic [4:0] adr, input logic [15:0] d,
                     input logic [3:0] sel);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= {16'h0000, d};
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    if (wb_ack_o !== 1'b1) begin
      n_errors++;
      report_and_stop();
    end
    rd = wb_dat_o[15:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  // Both byte lanes enabled
  task automatic wb(input logic we, input logic [4:0] adr, input logic [15:0] d);
    wbs(we, adr, d, 4'h3);
  endtask

  task automatic rchk(input logic [4:0] adr, input logic [15:0] exp);
    wb(1'b0, adr, 16'h0000);
    check(rd, exp);
  endtask

  task automatic mapchk(input mfr_map_ctl_s e);
    @(posedge clk_i);
    #1;
    check(16'(map_ctl_o), 16'(e));
  endtask

  // Expected {abort_req_o, trap_req_o} in the cycle after the event
  task automatic pulses(input logic [1:0] e);
    #1;
    check(16'({abort_req_o, trap_req_o}), 16'(e));
  endtask

  // ==========================================================
  // Scenarios
  task automatic s_reset();
    rchk(OFS_STATUS, ST_RESET);
    rchk(OFS_CHGLOG, 16'h0000);
    rchk(OFS_VPC, 16'h0000);
    rchk(OFS_CONFIG, 16'h0000);
    wb(1'b1, OFS_STATUS, 16'h0FFF);
    mapchk({1'b0, 1'b1, 3'h0, AMAP_18, 1'b0});
    rchk(OFS_STATUS, 16'h0381);
    wb(1'b1, OFS_STATUS, 16'h0001);
    mapchk({1'b1, 1'b1, 3'h0, AMAP_18, 1'b0});
    wbs(1'b1, OFS_STATUS, 16'h037E, 4'h2);
    rchk(OFS_STATUS, 16'h0381);
    wbs(1'b1, OFS_STATUS, 16'h0300, 4'h1);
    mapchk({1'b0, 1'b0, 3'h0, AMAP_16, 1'b0});
    rchk(OFS_STATUS, 16'h0380);
    wb(1'b1, OFS_STATUS, 16'h0001);
    wb(1'b1, 5'h10, 16'hFFFF);
    rchk(5'h10, 16'h0000);
  endtask

  task automatic s_config();
    wb(1'b1, OFS_CONFIG, 16'hFFFF);
    mapchk({1'b1, 1'b1, 3'h7, AMAP_22, 1'b1});
    rchk(OFS_CONFIG, 16'h0037);
    wb(1'b1, OFS_STATUS, 16'h0000);
    mapchk({1'b0, 1'b0, 3'h7, AMAP_16, 1'b1});
    wb(1'b1, OFS_CONFIG, 16'h0001);
    mapchk({1'b0, 1'b0, 3'h1, AMAP_16, 1'b0});
  endtask

  task automatic s_capture();
    wb(1'b1, OFS_VPC, 16'hFFFF);
    rchk(OFS_VPC, 16'h0000);
    mfr_core_model_i.fetch(16'h1234);
    rchk(OFS_VPC, 16'h1234);
    mfr_core_model_i.autoinc(3'h2, 5'h1E);
    mfr_core_model_i.autoinc(3'h7, 5'h02);
    mfr_core_model_i.autoinc(3'h3, 5'h01);
    rchk(OFS_CHGLOG, 16'h17F2);
    mfr_core_model_i.fetch(16'h0100);
    rchk(OFS_CHGLOG, 16'h0000);
    mfr_core_model_i.hw_trap(16'h00F4);
    rchk(OFS_VPC, 16'h00F4);
    rchk(OFS_STATUS, 16'h0000);
    mfr_core_model_i.instr_end(1'b1);
    rchk(OFS_STATUS, 16'h0000);
    mfr_core_model_i.instr_end(1'b0);
    rchk(OFS_STATUS, 16'h0080);
  endtask

  task automatic s_abort();
    mfr_core_model_i.mem_ref(2'h3, 1'b1, 3'h5, 1'b0, 3'b100);
    pulses(2'b00);
    wb(1'b1, OFS_STATUS, 16'h0001);
    mfr_core_model_i.fetch(16'h3000);
    mfr_core_model_i.autoinc(3'h6, 5'h1E);
    mfr_core_model_i.mem_ref(2'h3, 1'b1, 3'h5, 1'b0, 3'b100);
    pulses(2'b10);
    rchk(OFS_STATUS, 16'h80FB);
    mfr_core_model_i.mem_ref(2'h0, 1'b0, 3'h1, 1'b0, 3'b010);
    pulses(2'b00);
    mfr_core_model_i.fetch(16'h4444);
    mfr_core_model_i.autoinc(3'h1, 5'h02);
    rchk(OFS_STATUS, 16'h80FB);
    rchk(OFS_VPC, 16'h3000);
    rchk(OFS_CHGLOG, 16'h00F6);
    // Recovery backs the stack pointer out by the logged amount
    check(16'h0FFE - {{11{rd[7]}}, rd[7:3]}, 16'h1000);
    wb(1'b1, OFS_STATUS, 16'h0001);
    mfr_core_model_i.fetch(16'h2222);
    rchk(OFS_VPC, 16'h2222);
    wb(1'b1, OFS_STATUS, 16'h2001);
    mfr_core_model_i.fetch(16'h3333);
    rchk(OFS_VPC, 16'h2222);
    wb(1'b1, OFS_STATUS, 16'h0001);
  endtask

  task automatic s_maint();
    wb(1'b1, OFS_STATUS, 16'h0101);
    mfr_core_model_i.mem_ref(2'h2, 1'b0, 3'h0, 1'b0, 3'b100);
    pulses(2'b00);
    mfr_core_model_i.mem_ref(2'h2, 1'b0, 3'h0, 1'b1, 3'b000);
    pulses(2'b10);
    rchk(OFS_STATUS, 16'hC1C1);
    wb(1'b1, OFS_STATUS, 16'h0001);
    mfr_core_model_i.ro_ref(2'h0, 1'b1, 3'h7);
    pulses(2'b10);
    rchk(OFS_STATUS, 16'h209F);
    wb(1'b1, OFS_STATUS, 16'h0001);
  endtask

  task automatic s_trap();
    wb(1'b1, OFS_STATUS, 16'h0201);
    mfr_core_model_i.mem_ref(2'h1, 1'b0, 3'h3, 1'b0, 3'b001);
    mfr_core_model_i.mem_ref(2'h3, 1'b1, 3'h4, 1'b0, 3'b001);
    rchk(OFS_STATUS, 16'h12F9);
    wb(1'b1, OFS_STATUS, 16'h0001);
    mfr_core_model_i.instr_end(1'b0);
    pulses(2'b01);
    wb(1'b1, OFS_STATUS, 16'h0201);
    mfr_core_model_i.mem_ref(2'h1, 1'b0, 3'h3, 1'b0, 3'b001);
    mfr_core_model_i.mem_ref(2'h1, 1'b0, 3'h3, 1'b0, 3'b100);
    pulses(2'b10);
    mfr_core_model_i.instr_end(1'b0);
    pulses(2'b00);
    wb(1'b1, OFS_STATUS, 16'h0001);
  endtask

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    rst_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 5'h00;
    wb_sel_i = 4'h3;
    wb_dat_i = 32'h0000_0000;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    s_reset();
    s_config();
    s_capture();
    s_abort();
    s_maint();
    s_trap();
    report_and_stop();
  end

  initial begin
    #50000;
    n_errors++;
    report_and_stop();
  end
endmodule // mfr_regs_tb

// *** hdl/mfr_chg_log.sv ***
// Two-entry log of register autoincrement and autodecrement changes
`timescale 1ns/10ps
module mfr_chg_log
  import mfr_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        clear_i,
  input  wire logic        hold_i,
  input  wire logic        log_i,
  input  wire logic [2:0]  reg_i,
  input  wire logic [4:0]  amt_i,
  output logic      [15:0] log_o
);

  logic [1:0]  fill;
  logic [1:0]  next_fill;
  logic [15:0] next_log;
  logic [1:0]  base_fill;
  logic [15:0] base_log;

  // A fetch restarts the log before this cycle's change is added
  assign base_fill = clear_i ? 2'h0 : fill;
  assign base_log  = clear_i ? 16'h0000 : log_o;

  always_comb begin
    next_fill = base_fill;
    next_log  = base_log;
    if (log_i && base_fill == 2'h0) begin
      next_log[7:0] = {amt_i, reg_i};
      next_fill     = 2'h1;
    end else if (log_i && base_fill == 2'h1) begin
      next_log[15:8] = {amt_i, reg_i};
      next_fill      = 2'h2;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fill  <= 2'h0;
      log_o <= 16'h0000;
    end else if (!hold_i) begin
      fill  <= next_fill;
      log_o <= next_log;
    end
  end

endmodule // mfr_chg_log

// *** hdl/mfr_pkg.sv ***
// Constants, carriers and field layout of the fault-recovery register block
// What this block does
// - Trap seen before or on the write clearing bit 9 is still taken at end.
// - Bit 8 set relocates only destination operand references.
// - Bit 7 clears on trace, parity, odd, timeout traps and interrupts only.
// - Bit 7 reads one after reset and ignores software writes.
// - Faulting processor mode lands in status bits 6:5.
// - Illegal mode 10 with relocation sets abort flags 15 and 14.
// - Status bit 4 records instruction space 0 or data space 1.
// - Status bits 3:1 capture the faulting page number.
// - Bit 0 set relocates and protects; clear passes addresses straight.
// - Change log clears at the start of every instruction fetch while no flag 15:13 is set.
// - The first two autoincrements or autodecrements log register number and amount; later ones are not logged.
// - First change in the low byte, second in the high byte.
// - Virtual PC loads fetch address, or vector on hardware traps.
// - Virtual PC register is read-only.
// - Config bits 0,1,2 enable data space for user, supervisor, kernel.
// - Config bit 3 is reserved and reads zero.
// - Bit 4 picks 18 or 22 bit mapping; 16 bit when relocation off.
// - Config bit 5 enables relocation in the I/O bus map.
// - Config resets to zero; bits 15:6 unused.
// - Software clears flags 15:12; capture resumes on the next reference.
// - After an abort, captured contents stay frozen for that first abort.
// - Latest trap is recorded; abort after trap gives one stack push.
// - Any flag 15:13 set freezes status 7:1, change log and virtual PC.
package mfr_pkg;

  // ==========================================================
  // Register map
  localparam logic [4:0] OFS_STATUS = 5'h00;
  localparam logic [4:0] OFS_CHGLOG = 5'h04;
  localparam logic [4:0] OFS_VPC    = 5'h08;
  localparam logic [4:0] OFS_CONFIG = 5'h0C;

  // ==========================================================
  // Status field positions
  localparam int ST_NONRES  = 15;
  localparam int ST_LENGTH  = 14;
  localparam int ST_RDONLY  = 13;
  localparam int ST_MMTRAP  = 12;
  localparam int ST_TRAPEN  = 9;
  localparam int ST_MAINT   = 8;
  localparam int ST_DONE    = 7;
  localparam int ST_MODE_LO = 5;
  localparam int ST_DSPACE  = 4;
  localparam int ST_PAGE_LO = 1;
  localparam int ST_RELOC   = 0;
  localparam logic [15:0] ST_RESET = 16'h0080;

  // ==========================================================
  // Configuration field positions
  localparam int CF_DUSER  = 0;
  localparam int CF_DKERN  = 2;
  localparam int CF_RSVD   = 3;
  localparam int CF_MAP22  = 4;
  localparam int CF_IOREL  = 5;
  localparam logic [5:0] CF_RESET = 6'h00;
  localparam logic [5:0] CF_WMASK = 6'h37;

  // ==========================================================
  // Modes and mapping widths
  localparam logic [1:0] MODE_ILLEGAL = 2'h2;
  localparam logic [1:0] AMAP_16 = 2'h0;
  localparam logic [1:0] AMAP_18 = 2'h1;
  localparam logic [1:0] AMAP_22 = 2'h2;

  // Events from the processor core, all one-cycle pulses with data
  typedef struct packed {
    logic        fetch;
    logic [15:0] fetch_va;
    logic        hw_trap;
    logic [15:0] vector;
    logic        instr_end;
    logic        sw_trap;
    logic        autoinc;
    logic [2:0]  ai_reg;
    logic [4:0]  ai_amt;
    logic        ref_valid;
    logic [1:0]  ref_mode;
    logic        ref_dspace;
    logic [2:0]  ref_page;
    logic        ref_dest;
    logic        ab_nonres;
    logic        ab_length;
    logic        ab_rdonly;
    logic        trap_cond;
  } mfr_core_ev_s;

  // Mapping controls handed to the relocation datapath
  typedef struct packed {
    logic       reloc_all;
    logic       reloc_dest;
    logic [2:0] dspace_en;
    logic [1:0] amap;
    logic       io_reloc;
  } mfr_map_ctl_s;

endpackage

// *** hdl/mfr_regs.sv ***
// Fault-recovery status, change log, virtual PC and mapping configuration
//
// The address map and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/10ps
module mfr_regs
  import mfr_pkg::*;
(
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         wb_cyc_i,
  input  wire logic         wb_stb_i,
  input  wire logic         wb_we_i,
  input  wire logic [4:0]   wb_adr_i,
  input  wire logic [3:0]   wb_sel_i,
  input  wire logic [31:0]  wb_dat_i,
  output logic      [31:0]  wb_dat_o,
  output logic              wb_ack_o,
  input  wire mfr_core_ev_s ev_i,
  output mfr_map_ctl_s      map_ctl_o,
  output logic              trap_req_o,
  output logic              abort_req_o
);

  // ==========================================================
  // Bus decode
  logic        req;
  logic        wr;
  logic        hit_st;
  logic        hit_log;
  logic        hit_vpc;
  logic        hit_cfg;
  logic        wr_lo;
  logic        wr_hi;
  logic [15:0] rd_word;

  assign req     = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr      = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  assign hit_st  = wb_adr_i == OFS_STATUS;
  assign hit_log = wb_adr_i == OFS_CHGLOG;
  assign hit_vpc = wb_adr_i == OFS_VPC;
  assign hit_cfg = wb_adr_i == OFS_CONFIG;
  assign wr_lo   = wr && wb_sel_i[0];
  assign wr_hi   = wr && wb_sel_i[1];

  // ==========================================================
  // State
  logic [15:0] st;
  logic [15:0] next_st;
  logic [5:0]  cfg;
  logic [5:0]  next_cfg;
  logic [15:0] vpc;
  logic [15:0] next_vpc;
  logic [15:0] chg_log;
  logic        trap_pend;
  logic        next_pend;

  // ==========================================================
  // Fault classification
  logic frozen;
  logic reloc_ref;
  logic ill_mode;
  logic f_nonres;
  logic f_length;
  logic abort_ev;
  logic trap_ev;
  logic capture;

  assign frozen    = |st[ST_NONRES:ST_RDONLY];
  // Maintenance mode maps destination operands only
  assign reloc_ref = ev_i.ref_valid && st[ST_RELOC]
                     && (!st[ST_MAINT] || ev_i.ref_dest);
  assign ill_mode  = reloc_ref && ev_i.ref_mode == MODE_ILLEGAL;
  assign f_nonres  = ev_i.ab_nonres || ill_mode;
  assign f_length  = ev_i.ab_length || ill_mode;
  assign abort_ev  = reloc_ref && (f_nonres || f_length || ev_i.ab_rdonly);
  assign trap_ev   = reloc_ref && ev_i.trap_cond;
  // Captures restart once software has cleared the flags
  assign capture   = (abort_ev || trap_ev) && !frozen;

  // ==========================================================
  // Status register next value
  always_comb begin
    next_st = st;
    if (wr_hi && hit_st) begin
      next_st[15:12]    = wb_dat_i[15:12];
      next_st[ST_TRAPEN] = wb_dat_i[ST_TRAPEN];
      next_st[ST_MAINT] = wb_dat_i[ST_MAINT];
    end
    if (wr_lo && hit_st) begin
      next_st[ST_RELOC] = wb_dat_i[ST_RELOC];
    end
    // Instruction-completed is hardware owned
    if (!frozen && ev_i.instr_end && !ev_i.sw_trap) begin
      next_st[ST_DONE] = 1'b1;
    end
    if (!frozen && ev_i.hw_trap) begin
      next_st[ST_DONE] = 1'b0;
    end
    // Hardware set wins over a software clear in the same cycle
    if (abort_ev && !frozen) begin
      next_st[ST_NONRES] = st[ST_NONRES] || f_nonres;
      next_st[ST_LENGTH] = st[ST_LENGTH] || f_length;
      next_st[ST_RDONLY] = st[ST_RDONLY] || ev_i.ab_rdonly;
    end
    if (trap_ev && !frozen) begin
      next_st[ST_MMTRAP] = 1'b1;
    end
    // Latest trap or first abort describes the fault
    if (capture) begin
      next_st[6:5] = ev_i.ref_mode;
      next_st[ST_DSPACE] = ev_i.ref_dspace;
      next_st[3:1] = ev_i.ref_page;
    end
    next_st[11:10] = 2'b00;
  end

  // ==========================================================
  // Virtual PC next value
  always_comb begin
    next_vpc = vpc;
    if (ev_i.fetch) begin
      next_vpc = ev_i.fetch_va;
    end
    if (ev_i.hw_trap) begin
      next_vpc = ev_i.vector;
    end
  end

  // Configuration writes: reserved bit 3 never stored
  assign next_cfg = (wr_lo && hit_cfg) ? (wb_dat_i[5:0] & CF_WMASK)
                                       : cfg;

  // ==========================================================
  // Trap pending across the instruction
  always_comb begin
    next_pend = trap_pend;
    // Uses the enable as it stood before this reference's write
    if (trap_ev && st[ST_TRAPEN]) begin
      next_pend = 1'b1;
    end
    if (ev_i.instr_end) begin
      next_pend = 1'b0;
    end
    // An abort takes over, so only one stack push happens
    if (abort_ev) begin
      next_pend = 1'b0;
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= ST_RESET;
      cfg <= CF_RESET;
      trap_pend <= 1'b0;
    end else begin
      st <= next_st;
      cfg <= next_cfg;
      trap_pend <= next_pend;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vpc <= 16'h0000;
    end else if (!frozen) begin
      vpc <= next_vpc;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trap_req_o  <= 1'b0;
      abort_req_o <= 1'b0;
    end else begin
      trap_req_o  <= trap_pend && ev_i.instr_end && !abort_ev;
      abort_req_o <= abort_ev && !frozen;
    end
  end

  // ==========================================================
  // Register-change log
  mfr_chg_log u_log (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .clear_i (ev_i.fetch),
    .hold_i  (frozen),
    .log_i   (ev_i.autoinc),
    .reg_i   (ev_i.ai_reg),
    .amt_i   (ev_i.ai_amt),
    .log_o   (chg_log)
  );

  // ==========================================================
  // Mapping controls
  mfr_map_ctl_s next_ctl;

  assign next_ctl.reloc_all  = st[ST_RELOC] && !st[ST_MAINT];
  assign next_ctl.reloc_dest = st[ST_RELOC];
  assign next_ctl.dspace_en  = cfg[CF_DKERN:CF_DUSER];
  assign next_ctl.amap       = !st[ST_RELOC] ? AMAP_16
                               : cfg[CF_MAP22] ? AMAP_22
                               : AMAP_18;
  assign next_ctl.io_reloc   = cfg[CF_IOREL];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      map_ctl_o <= '0;
    end else begin
      map_ctl_o <= next_ctl;
    end
  end

  // ==========================================================
  // Read mux and acknowledge; virtual PC and log ignore writes
  assign rd_word = hit_st  ? st
                 : hit_log ? chg_log
                 : hit_vpc ? vpc
                 : hit_cfg ? {10'h000, cfg}
                 : 16'h0000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      if (req) begin
        wb_dat_o <= {16'h0000, rd_word};
      end
    end
  end

  // ==========================================================
  // Checks
  chk_trap_after_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    trap_pend && ev_i.instr_end && !abort_ev |=> trap_req_o)
    else $error("pending trap not raised at instruction end");

  chk_dest_only_map: assert property (@(posedge clk_i) disable iff (rst_i)
    st[ST_RELOC] && st[ST_MAINT] |=> !map_ctl_o.reloc_all
      && map_ctl_o.reloc_dest)
    else $error("maintenance mode relocates non-destination refs");

  chk_done_cleared: assert property (@(posedge clk_i) disable iff (rst_i)
    ev_i.hw_trap && !frozen |=> !st[ST_DONE])
    else $error("instruction-completed not cleared by trap");

  chk_done_reset: assert property (@(posedge clk_i)
    rst_i |=> st[ST_DONE])
    else $error("instruction-completed not one after reset");

  chk_ill_mode_flags: assert property (@(posedge clk_i) disable iff (rst_i)
    ill_mode && !frozen |=> st[ST_NONRES] && st[ST_LENGTH])
    else $error("illegal mode did not set both abort flags");

  chk_page_capture: assert property (@(posedge clk_i) disable iff (rst_i)
    capture |=> st[3:1] == $past(ev_i.ref_page)
      && st[6:5] == $past(ev_i.ref_mode))
    else $error("fault page or mode not captured");

  chk_freeze_holds: assert property (@(posedge clk_i) disable iff (rst_i)
    frozen |=> $stable(vpc) && $stable(chg_log)
      && $stable(st[7:1]))
    else $error("frozen fault state changed");

  chk_fetch_vpc: assert property (@(posedge clk_i) disable iff (rst_i)
    ev_i.fetch && !ev_i.hw_trap && !frozen
      |=> vpc == $past(ev_i.fetch_va))
    else $error("virtual PC missed the fetch address");

  chk_log_cleared: assert property (@(posedge clk_i) disable iff (rst_i)
    ev_i.fetch && !ev_i.autoinc && !frozen |=> chg_log == 16'h0000)
    else $error("change log not cleared on fetch");

  chk_cfg_reserved: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o && $past(hit_cfg) && !$past(wb_we_i)
      |-> wb_dat_o[15:6] == 10'h000 && wb_dat_o[CF_RSVD] == 1'b0)
    else $error("reserved config bit read as one");

  chk_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge held longer than one cycle");

  chk_space_capture: assert property (@(posedge clk_i) disable iff (rst_i)
    capture |=> st[ST_DSPACE] == $past(ev_i.ref_dspace))
    else $error("fault address space not captured");

  chk_done_sw_trap: assert property (@(posedge clk_i) disable iff (rst_i)
    ev_i.instr_end && ev_i.sw_trap && !ev_i.hw_trap |=> $stable(st[ST_DONE]))
    else $error("software trap changed instruction-completed");

  chk_reloc_off: assert property (@(posedge clk_i) disable iff (rst_i)
    !st[ST_RELOC] |=> !map_ctl_o.reloc_all && !map_ctl_o.reloc_dest
      && map_ctl_o.amap == AMAP_16)
    else $error("mapping active with relocation off");

  chk_map22_sel: assert property (@(posedge clk_i) disable iff (rst_i)
    st[ST_RELOC] && cfg[CF_MAP22] |=> map_ctl_o.amap == AMAP_22)
    else $error("22-bit mapping not selected");

  chk_dspace_cfg: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |=> map_ctl_o.dspace_en == $past(cfg[CF_DKERN:CF_DUSER]))
    else $error("data-space enables differ from configuration");

  chk_io_reloc: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |=> map_ctl_o.io_reloc == $past(cfg[CF_IOREL]))
    else $error("bus map relocation differs from configuration");

  chk_cfg_reset: assert property (@(posedge clk_i)
    rst_i |=> cfg == CF_RESET)
    else $error("configuration not zero after reset");

  chk_vpc_vector: assert property (@(posedge clk_i) disable iff (rst_i)
    ev_i.hw_trap && !frozen |=> vpc == $past(ev_i.vector))
    else $error("virtual PC missed the trap vector");

  chk_vpc_readonly: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && hit_vpc && !ev_i.fetch && !ev_i.hw_trap |=> $stable(vpc))
    else $error("software write changed the virtual PC");

  chk_abort_once: assert property (@(posedge clk_i) disable iff (rst_i)
    frozen |=> !abort_req_o)
    else $error("later error reported after first abort");

  chk_single_push: assert property (@(posedge clk_i) disable iff (rst_i)
    abort_ev |=> !trap_pend && !trap_req_o)
    else $error("trap raised alongside an abort");

  cov_abort_seen: cover property (@(posedge clk_i) disable iff (rst_i)
    abort_ev && !frozen ##1 frozen);

  cov_trap_taken: cover property (@(posedge clk_i) disable iff (rst_i)
    trap_req_o);

  cov_abort_after_trap: cover property (@(posedge clk_i) disable iff (rst_i)
    trap_pend ##[1:20] abort_ev);

  cov_two_changes: cover property (@(posedge clk_i) disable iff (rst_i)
    ev_i.autoinc ##[1:10] ev_i.autoinc);

endmodule // mfr_regs
